// >>> src/fpd_pkg.sv
package fpd_pkg;

	// ---------------------------------------------------------------
	// sizes of the download region and the ram port
	// ---------------------------------------------------------------
	localparam int FPD_RAM_AW = 14;
	localparam int FPD_CNT_W = 11;
	localparam int FPD_CODE_W = 3;
	localparam logic [10:0] FPD_LAST_IDX = 11'h7ff;
	localparam logic [10:0] FPD_IDX_ZERO = 11'h000;
	localparam logic [7:0] FPD_TARGET_MAX = 8'h07;
	localparam logic [7:0] FPD_KEY_OK = 8'ha5;

	// ---------------------------------------------------------------
	// register byte offsets on the axi4-lite bus
	// ---------------------------------------------------------------
	localparam logic [11:0] FPD_OFS_CTRL = 12'h000;
	localparam logic [11:0] FPD_OFS_KEY = 12'h004;
	localparam logic [11:0] FPD_OFS_TARGET = 12'h008;
	localparam logic [11:0] FPD_OFS_STATUS = 12'h00c;
	localparam logic [11:0] FPD_OFS_INT_STAT = 12'h010;
	localparam logic [11:0] FPD_OFS_INT_MASK = 12'h014;
	localparam logic [11:0] FPD_OFS_RESULT = 12'h018;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int FPD_CTRL_START = 0;
	localparam int FPD_CTRL_SEL_PROG = 1;
	localparam int FPD_CTRL_SEL_ERASE = 2;
	localparam int FPD_CTRL_MAP_EN = 3;
	localparam int FPD_STAT_BUSY = 0;
	localparam int FPD_STAT_TARGET_ADDR_ERROR = 1;
	localparam int FPD_STAT_RES_LSB = 8;
	localparam int FPD_INT_DONE = 0;
	localparam int FPD_INT_ABORT = 1;
	localparam logic [4:0] FPD_RES_ZERO = 5'h00;

	// ---------------------------------------------------------------
	// bus answers and routine image salts
	// ---------------------------------------------------------------
	localparam logic [1:0] FPD_RESP_OKAY = 2'h0;
	localparam logic [1:0] FPD_RESP_SLVERR = 2'h2;
	localparam logic [7:0] FPD_SALT_PROG = 8'h3c;
	localparam logic [7:0] FPD_SALT_ERASE = 8'hc3;

	typedef enum logic [4:0] {
		FPD_ST_IDLE = 5'h01,
		FPD_ST_CHECK = 5'h02,
		FPD_ST_COPY = 5'h04,
		FPD_ST_VERIFY = 5'h08,
		FPD_ST_RESULT = 5'h10
	} fpd_fsm_type;

endpackage

// >>> src/fpd_routine_rom.sv
`timescale 1ns/1ps
module fpd_routine_rom
	import fpd_pkg::*;
(
	// routine byte lookup
	input wire logic [fpd_pkg::FPD_CNT_W-1:0] idx,
	input wire logic erase_sel,
	output logic [7:0] data
);
	import fpd_pkg::*;

	// ---------------------------------------------------------------
	// built-in routine image
	// ---------------------------------------------------------------
	// the image is a fixed function of the index and the routine selection, so it needs no storage
	// and the verify pass can recompute each expected byte
	always_comb
	begin
		data = idx[7:0] ^ {idx[10:8], FPD_RES_ZERO} ^
			(erase_sel ? FPD_SALT_ERASE : FPD_SALT_PROG);
	end

endmodule

// >>> src/fpd_download_ctrl.sv
// Functional notes
// - writing one to the start bit copies the selected routine on its own
// - the copy fills a 2-kilobyte ram region starting at the target base
// - the result byte goes to the first ram byte of the region
// - result bits 7 to 3 are always written as zero
// - bit 2 flags no, several, or unmapped routine selection
// - bit 1 flags a key register value other than a5
// - copied bytes are read back; bit 0 is one on mismatch or when a bad selection or key skips the copy
// - the block writes no cpu register other than the result byte
// - operation results are handed back in the first region byte and the status result field
// - ram and cpu parameter locations have no guaranteed reset value
// - target codes 08 to ff set the target error and abort
`timescale 1ns/1ps
module fpd_download_ctrl
	import fpd_pkg::*;
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// on-chip ram byte port
	output logic [fpd_pkg::FPD_RAM_AW-1:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic ram_we,
	output logic ram_re,
	input wire logic [7:0] ram_rdata,
	// cpu side
	output logic [7:0] cpu_result_byte,
	output logic irq
);
	import fpd_pkg::*;
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		fpd_fsm_type fsm;
		logic [FPD_CNT_W-1:0] cnt;
		logic issued_all;
		logic v1;
		logic v2;
		logic [7:0] exp1;
		logic [7:0] exp2;
		logic fail;
		logic ss_err;
		logic fk_err;
		logic routine_erase;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic sel_prog;
		logic sel_erase;
		logic map_en;
		logic [7:0] key;
		logic [7:0] target;
		logic target_addr_error;
		logic [7:0] result_byte;
		logic [1:0] int_stat;
		logic [1:0] int_mask;
		logic [7:0] cpu_result;
		logic [FPD_RAM_AW-1:0] ram_addr;
		logic [7:0] ram_wdata;
		logic ram_we;
		logic ram_re;
		logic irq;
	} fpd_regs_type;
	fpd_regs_type r;
	fpd_regs_type next_r;
	logic [7:0] rom_data;
	logic [FPD_RAM_AW-1:0] base_addr;
	logic [FPD_RAM_AW-1:0] cur_addr;

	// ---------------------------------------------------------------
	// routine image and region addressing
	// ---------------------------------------------------------------
	fpd_routine_rom u_rom
	(
		.idx(r.cnt),
		.erase_sel(r.routine_erase),
		.data(rom_data)
	);

	// codes 00 to 07 pick one of eight aligned 2-kilobyte windows
	assign base_addr = {r.target[FPD_CODE_W-1:0], {FPD_CNT_W{1'b0}}};
	assign cur_addr = base_addr + FPD_RAM_AW'(r.cnt);

	// ---------------------------------------------------------------
	// bus handshakes and outputs
	// ---------------------------------------------------------------
	assign awready = ce && !r.aw_held && !r.bvalid;
	assign wready = ce && !r.w_held && !r.bvalid;
	assign arready = ce && !r.rvalid;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign ram_addr = r.ram_addr;
	assign ram_wdata = r.ram_wdata;
	assign ram_we = r.ram_we;
	assign ram_re = r.ram_re;
	// only the result byte and irq leave toward the cpu; nothing else is driven
	assign cpu_result_byte = r.cpu_result;
	assign irq = r.irq;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic start_req;
		logic ev_done;
		logic ev_abort;
		logic rd_clr;
		logic [31:0] rd_val;
		logic rd_hit;
		logic wr_hit;
		logic lane0;
		start_req = 1'b0;
		ev_done = 1'b0;
		ev_abort = 1'b0;
		rd_clr = 1'b0;
		rd_val = 32'h0;
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		lane0 = r.w_strb[0];
		next_r = r;
		if (ce)
		begin
			next_r.ram_we = 1'b0;
			next_r.ram_re = 1'b0;
			// write channel: address and data taken in either order
			if (awvalid && awready)
			begin
				next_r.aw_held = 1'b1;
				next_r.aw_addr = awaddr;
			end
			if (wvalid && wready)
			begin
				next_r.w_held = 1'b1;
				next_r.w_data = wdata;
				next_r.w_strb = wstrb;
			end
			if (r.bvalid && bready)
				next_r.bvalid = 1'b0;
			if (r.aw_held && r.w_held && !r.bvalid)
			begin
				next_r.aw_held = 1'b0;
				next_r.w_held = 1'b0;
				next_r.bvalid = 1'b1;
				unique case (r.aw_addr)
					FPD_OFS_CTRL:
						if (lane0)
						begin
							next_r.sel_prog = r.w_data[FPD_CTRL_SEL_PROG];
							next_r.sel_erase = r.w_data[FPD_CTRL_SEL_ERASE];
							next_r.map_en = r.w_data[FPD_CTRL_MAP_EN];
							start_req = r.w_data[FPD_CTRL_START];
						end
					FPD_OFS_KEY:
						if (lane0)
							next_r.key = r.w_data[7:0];
					FPD_OFS_TARGET:
						if (lane0)
							next_r.target = r.w_data[7:0];
					FPD_OFS_INT_MASK:
						if (lane0)
							next_r.int_mask = r.w_data[1:0];
					FPD_OFS_RESULT:
						if (lane0)
							next_r.cpu_result = r.w_data[7:0];
					FPD_OFS_STATUS, FPD_OFS_INT_STAT:
						wr_hit = 1'b1;
					default:
						wr_hit = 1'b0;
				endcase
				next_r.bresp = wr_hit ? FPD_RESP_OKAY : FPD_RESP_SLVERR;
			end
			// read channel: one cycle from address to data
			if (r.rvalid && rready)
				next_r.rvalid = 1'b0;
			if (arvalid && arready)
			begin
				unique case (araddr)
					FPD_OFS_CTRL:
					begin
						rd_val[FPD_CTRL_START] = r.fsm != FPD_ST_IDLE;
						rd_val[FPD_CTRL_SEL_PROG] = r.sel_prog;
						rd_val[FPD_CTRL_SEL_ERASE] = r.sel_erase;
						rd_val[FPD_CTRL_MAP_EN] = r.map_en;
					end
					FPD_OFS_KEY:
						rd_val[7:0] = r.key;
					FPD_OFS_TARGET:
						rd_val[7:0] = r.target;
					FPD_OFS_STATUS:
					begin
						rd_val[FPD_STAT_BUSY] = r.fsm != FPD_ST_IDLE;
						rd_val[FPD_STAT_TARGET_ADDR_ERROR] = r.target_addr_error;
						rd_val[FPD_STAT_RES_LSB +: 8] = r.result_byte;
					end
					FPD_OFS_INT_STAT:
					begin
						rd_val[1:0] = r.int_stat;
						rd_clr = 1'b1;
					end
					FPD_OFS_INT_MASK:
						rd_val[1:0] = r.int_mask;
					FPD_OFS_RESULT:
						rd_val[7:0] = r.cpu_result;
					default:
						rd_hit = 1'b0;
				endcase
				next_r.rvalid = 1'b1;
				next_r.rdata = rd_val;
				next_r.rresp = rd_hit ? FPD_RESP_OKAY : FPD_RESP_SLVERR;
			end
			// download sequencer
			unique case (r.fsm)
				FPD_ST_IDLE:
					// a start while busy is ignored, not queued
					if (start_req)
						next_r.fsm = FPD_ST_CHECK;
				FPD_ST_CHECK:
				begin
					if (r.target > FPD_TARGET_MAX)
					begin
						next_r.target_addr_error = 1'b1;
						ev_abort = 1'b1;
						next_r.fsm = FPD_ST_IDLE;
					end
					else
					begin
						next_r.target_addr_error = 1'b0;
						next_r.ss_err = !(r.map_en &&
							(r.sel_prog ^ r.sel_erase));
						next_r.fk_err = r.key != FPD_KEY_OK;
						next_r.routine_erase = r.sel_erase;
						next_r.cnt = FPD_IDX_ZERO;
						next_r.issued_all = 1'b0;
						next_r.v1 = 1'b0;
						next_r.v2 = 1'b0;
						next_r.fail = 1'b0;
						// a bad selection or key skips the copy
						if (next_r.ss_err || next_r.fk_err)
						begin
							next_r.fail = 1'b1;
							next_r.fsm = FPD_ST_RESULT;
						end
						else
							next_r.fsm = FPD_ST_COPY;
					end
				end
				FPD_ST_COPY:
				begin
					next_r.ram_we = 1'b1;
					next_r.ram_addr = cur_addr;
					next_r.ram_wdata = rom_data;
					next_r.cnt = r.cnt + 1'b1;
					if (r.cnt == FPD_LAST_IDX)
						next_r.fsm = FPD_ST_VERIFY;
				end
				FPD_ST_VERIFY:
				begin
					// two-stage pipe: ram answers the cycle after ram_re
					next_r.v1 = 1'b0;
					if (!r.issued_all)
					begin
						next_r.ram_re = 1'b1;
						next_r.ram_addr = cur_addr;
						next_r.exp1 = rom_data;
						next_r.v1 = 1'b1;
						next_r.cnt = r.cnt + 1'b1;
						if (r.cnt == FPD_LAST_IDX)
							next_r.issued_all = 1'b1;
					end
					next_r.v2 = r.v1;
					next_r.exp2 = r.exp1;
					if (r.v2 && ram_rdata != r.exp2)
						next_r.fail = 1'b1;
					if (r.issued_all && !r.v1 && !r.v2)
						next_r.fsm = FPD_ST_RESULT;
				end
				FPD_ST_RESULT:
				begin
					// one write after all checks: a poller sees no half byte
					next_r.ram_we = 1'b1;
					next_r.ram_addr = base_addr;
					next_r.ram_wdata = {FPD_RES_ZERO, r.ss_err,
						r.fk_err, r.fail};
					next_r.result_byte = {FPD_RES_ZERO, r.ss_err,
						r.fk_err, r.fail};
					ev_done = 1'b1;
					next_r.fsm = FPD_ST_IDLE;
				end
			endcase
			// sticky events; a new event beats the read that clears
			next_r.int_stat = (rd_clr ? 2'h0 : r.int_stat) |
				{ev_abort, ev_done};
			next_r.irq = |(next_r.int_stat & next_r.int_mask);
		end
		// only control state resets; key, target and result stay undefined
		if (!aresetn)
		begin
			next_r.fsm = FPD_ST_IDLE;
			next_r.cnt = FPD_IDX_ZERO;
			next_r.issued_all = 1'b0;
			next_r.v1 = 1'b0;
			next_r.v2 = 1'b0;
			next_r.aw_held = 1'b0;
			next_r.w_held = 1'b0;
			next_r.bvalid = 1'b0;
			next_r.bresp = FPD_RESP_OKAY;
			next_r.rvalid = 1'b0;
			next_r.rdata = 32'h0;
			next_r.rresp = FPD_RESP_OKAY;
			next_r.sel_prog = 1'b0;
			next_r.sel_erase = 1'b0;
			next_r.map_en = 1'b0;
			next_r.target_addr_error = 1'b0;
			next_r.int_stat = 2'h0;
			next_r.int_mask = 2'h0;
			next_r.ram_we = 1'b0;
			next_r.ram_re = 1'b0;
			next_r.ram_addr = {FPD_RAM_AW{1'b0}};
			next_r.ram_wdata = 8'h0;
			next_r.irq = 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		r <= next_r;
	end

endmodule

// >>> test/fpd_download_ctrl_asserts.sv
`timescale 1ns/1ps
module fpd_download_ctrl_asserts
	import fpd_pkg::*;
(
	// clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// bus handshakes
	input wire logic awready,
	input wire logic wready,
	input wire logic arready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// ram port
	input wire logic [fpd_pkg::FPD_RAM_AW-1:0] ram_addr,
	input wire logic ram_we,
	input wire logic ram_re
);
	import fpd_pkg::*;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------------------------
	// ram and bus sequencing
	// ------------------------
	sequence s_we_run;
		ram_we ##1 ram_we;
	endsequence
	sequence s_re_run;
		ram_re ##1 ram_re;
	endsequence
	a_copy_step:
		assert property (s_we_run |-> ram_addr == $past(ram_addr) + 14'h1)
		else $error("copy address skipped");
	a_read_step:
		assert property (s_re_run |-> ram_addr == $past(ram_addr) + 14'h1)
		else $error("read back address skipped");
	a_no_early_result:
		assert property (ram_re |-> !ram_we ##1 !ram_we)
		else $error("write during read back");
	a_b_hold:
		assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	a_r_hold:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_aw_refused:
		assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answering");
	a_ar_refused:
		assert property (rvalid |-> !arready)
		else $error("read taken while answering");
	a_ce_freeze:
		assert property (!ce |-> !arready && !awready ##1 $stable(ram_addr))
		else $error("state moved while disabled");
	a_reset_quiet:
		assert property (disable iff (1'b0)
			!aresetn |=> !ram_we && !bvalid && !rvalid)
		else $error("outputs busy after reset");
endmodule

bind fpd_download_ctrl fpd_download_ctrl_asserts chk_u (.aclk, .aresetn, .ce,
	.awready, .wready, .arready, .bvalid, .bready, .rdata, .rvalid, .rready,
	.ram_addr, .ram_we, .ram_re);

// >>> test/fpd_ram_model.sv
`timescale 1ns/1ps
module fpd_ram_model
	import fpd_pkg::*;
(
	// ram byte port
	input wire logic aclk,
	input wire logic [fpd_pkg::FPD_RAM_AW-1:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic ram_we,
	input wire logic ram_re,
	output logic [7:0] ram_rdata,
	// fault injection: corrupt every read while high
	input wire logic flip_en
);
	logic [7:0] mem [0:16383];
	// outside a read cycle the data toggles, so stale data never matches
	always @(posedge aclk)
	begin
		if (ram_we)
			mem[ram_addr] <= ram_wdata;
		if (ram_re)
			ram_rdata <= mem[ram_addr] ^ {7'h00, flip_en};
		else
			ram_rdata <= ~ram_rdata;
	end
endmodule

// >>> test/flash_program_download_control_tb.sv
`timescale 1ns/1ps
module flash_program_download_control_tb;
	import fpd_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic flip = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, ram_we, ram_re, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [13:0] ram_addr;
	logic [7:0] ram_wdata, ram_rdata, cpu_result_byte;
	logic [7:0] sel [3] = '{8'h09, 8'h0f, 8'h03};
	logic [7:0] bad [2] = '{8'h08, 8'hff};
	logic msk = 1'b1;
	int n_fail = 0;
	int n_checks = 0;
	int nwe = 0;
	always #20 aclk = ~aclk;
	always @(posedge aclk) if (ram_we) nwe++;
	fpd_download_ctrl dut_u (.aclk, .aresetn, .ce, .awaddr, .awprot(3'h0),
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ram_addr, .ram_wdata, .ram_we, .ram_re,
		.ram_rdata, .cpu_result_byte, .irq);
	fpd_ram_model ram_u (.aclk, .ram_addr, .ram_wdata, .ram_we, .ram_re,
		.ram_rdata, .flip_en(flip));
	// ----------------------
	// bus and check tasks
	// ----------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		tally_and_finish();
	endtask
	task automatic chk(input logic [33:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		bit ta, tw, aw, w;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw = 0;
		w = 0;
		for (n = 0; !(aw && w); n++)
		begin
			if (n > 50) hang();
			@(negedge aclk);
			ta = awready;
			tw = wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			aw |= ta;
			w |= tw;
		end
		bready <= 1'b1;
		ta = 0;
		for (n = 0; !ta; n++)
		begin
			if (n > 50) hang();
			@(negedge aclk);
			ta = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		bit t;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		for (n = 0; !t; n++)
		begin
			if (n > 50) hang();
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		t = 0;
		for (n = 0; !t; n++)
		begin
			if (n > 50) hang();
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask
	// one download: key, target, preset, start, poll, then compare
	task automatic dl(input logic [7:0] c, k, t, rb, input logic [10:0] o,
		input logic [7:0] e);
		logic [13:0] b;
		int n;
		b = {t[2:0], 11'h000};
		wr(FPD_OFS_KEY, {24'h0, k});
		wr(FPD_OFS_TARGET, {24'h0, t});
		ram_u.mem[b] = 8'hff;
		wr(FPD_OFS_CTRL, {24'h0, c});
		d = 32'h1;
		for (n = 0; d[0]; n++)
		begin
			if (n > 3000) hang();
			rd(FPD_OFS_STATUS);
		end
		chk(d[15:8], rb);
		chk(ram_u.mem[b], rb);
		if (o != 0) chk(ram_u.mem[b + o], e);
		chk(irq, msk);
		rd(FPD_OFS_INT_STAT);
		chk(d, 32'h1);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		chk(cpu_result_byte, 8'h5a);
		$display("download test done");
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(FPD_OFS_STATUS);
		// the result field has no value until the first download
		chk({d[31:16], d[7:0]}, 24'h0);
		rd(12'h0fc);
		chk({r, d}, {FPD_RESP_SLVERR, 32'h0});
		wr(12'h0fc, 32'h1);
		chk(r, FPD_RESP_SLVERR);
		wr(FPD_OFS_RESULT, 32'h5a);
		chk(cpu_result_byte, 8'h5a);
		// lane 0 strobe low: the write is answered but changes nothing
		wstrb <= 4'he;
		wr(FPD_OFS_RESULT, 32'h33);
		wstrb <= 4'hf;
		chk(r, FPD_RESP_OKAY);
		chk(cpu_result_byte, 8'h5a);
		$display("register test done");
		wr(FPD_OFS_INT_MASK, 32'h3);
		// the bench plays the cpu; its parameter registers stay here
		ram_u.mem[14'h3f80] = 8'h77;
		dl(8'h0b, 8'ha5, 8'h03, 8'h00, 11'h005, 8'h39);
		chk(ram_u.mem[14'h3f80], 8'h77);
		dl(8'h0d, 8'ha5, 8'h07, 8'h00, 11'h7ff, 8'hdc);
		dl(8'h0b, 8'h5a, 8'h00, 8'h03, 11'h0, 8'h0);
		foreach (sel[i])
			dl(sel[i], 8'ha5, 8'h02, 8'h05, 11'h0, 8'h0);
		flip <= 1'b1;
		dl(8'h0b, 8'ha5, 8'h01, 8'h01, 11'h0, 8'h0);
		flip <= 1'b0;
		msk = 1'b0;
		wr(FPD_OFS_INT_MASK, 32'h0);
		dl(8'h0b, 8'ha5, 8'h04, 8'h00, 11'h0, 8'h0);
		foreach (bad[i])
		begin
			nwe = 0;
			wr(FPD_OFS_TARGET, {24'h0, bad[i]});
			wr(FPD_OFS_CTRL, 32'h0b);
			repeat (8) @(posedge aclk);
			rd(FPD_OFS_STATUS);
			chk(d[1:0], 2'h2);
			rd(FPD_OFS_INT_STAT);
			chk(d, 32'h2);
			chk(nwe, 0);
			$display("abort test done");
		end
		ce <= 1'b0;
		repeat (4) @(posedge aclk);
		ce <= 1'b1;
		rd(FPD_OFS_RESULT);
		chk(d, 32'h5a);
		$display("freeze test done");
		tally_and_finish();
	end
endmodule
